//--- cmbh_field_mask.sv
/*
 Masks unimplemented upper bits of a buffer word so they read as zero.
 Assumes the mask comes from the package.
*/
`timescale 1ns/1ps
`default_nettype none
module cmbh_field_mask #(
    parameter logic [15:0] MASK = 16'hFFFF
) (
    input wire logic [15:0] raw, // Word as stored in RAM
    output logic [15:0] masked // Word with unimplemented bits zero
);
    // ==========================================
    // Zero the unimplemented bits
    assign masked = raw & MASK;
endmodule // cmbh_field_mask
`default_nettype wire

//--- cmbh_header_reader.sv
/*
 Controller-side reader of the first message buffer words. It fetches
 words 0, 1 and 2 from data RAM at a software-chosen base and decodes
 the identifier, format and remote request for the frame builder.
 Assumes a RAM port with one cycle of read latency on the same clock.
*/
// Functional notes
// - Buffers live in general data RAM; controller reads them from there.
// - Word 0 bits 12..2 hold base identifier; bits 15..13 read zero.
// - With standard format, word 0 bit 1 selects remote or data frame.
// - Word 0 bit 0 selects extended or standard identifier format.
// - Word 1 bits 11..0 hold extension bits 17..6; upper bits zero.
`timescale 1ns/1ps
`default_nettype none
module cmbh_header_reader
    import cmbh_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] buf_base, // Word address of buffer
    input wire logic start, // Pulse: fetch header
    output logic busy, // Fetch in progress
    output logic ram_rd, // RAM read strobe
    output logic [ADDR_W-1:0] ram_addr, // RAM word address
    input wire logic [15:0] ram_rdata, // RAM data, one cycle after strobe
    output logic [15:0] word0_view, // Word 0 with reserved bits zero
    output logic [15:0] word1_view, // Word 1 with reserved bits zero
    output cmbh_pkg::cmbh_hdr_s hdr, // Decoded header
    output logic hdr_valid // Pulse: header ready
);
    import cmbh_pkg::*;

    typedef enum logic [2:0] {
        CMBH_IDLE = 3'b000,
        CMBH_RD0 = 3'b001,
        CMBH_RD1 = 3'b010,
        CMBH_RD2 = 3'b011,
        CMBH_DONE = 3'b100
    } cmbh_state_e;

    cmbh_state_e state;
    cmbh_state_e next_state;
    logic [15:0] w0_raw;
    logic [15:0] w1_raw;
    logic [15:0] w2_raw;
    logic [1:0] rd_idx;
    logic rd_pend;
    logic [1:0] pend_idx;

    // ==========================================
    // Address of a word inside the buffer
    function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] base,
                                                   input logic [1:0] idx);
        word_addr = base + ADDR_W'(idx);
    endfunction

    // ==========================================
    // Fetch sequencing
    always_comb begin
        next_state = state;
        case (state)
            CMBH_IDLE: begin
                if (start) begin
                    next_state = CMBH_RD0;
                end
            end
            CMBH_RD0: next_state = CMBH_RD1;
            CMBH_RD1: next_state = CMBH_RD2;
            CMBH_RD2: next_state = CMBH_DONE;
            CMBH_DONE: next_state = CMBH_IDLE;
            default: next_state = CMBH_IDLE;
        endcase
    end

    // RAM reads at the software-chosen base
    assign rd_idx = (state == CMBH_RD1) ? CMBH_WORD1_IDX :
                    (state == CMBH_RD2) ? CMBH_WORD2_IDX : CMBH_WORD0_IDX;
    assign ram_rd = (state == CMBH_RD0) || (state == CMBH_RD1) || (state == CMBH_RD2);
    assign ram_addr = word_addr(buf_base, rd_idx);
    assign busy = (state != CMBH_IDLE);

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= CMBH_IDLE;
            rd_pend <= 1'b0;
            pend_idx <= CMBH_WORD0_IDX;
        end else begin
            state <= next_state;
            rd_pend <= ram_rd;
            pend_idx <= rd_idx;
        end
    end

    // Capture returned words
    always_ff @(posedge clk) begin
        if (reset) begin
            w0_raw <= '0;
            w1_raw <= '0;
            w2_raw <= '0;
        end else if (rd_pend) begin
            case (pend_idx)
                CMBH_WORD0_IDX: w0_raw <= ram_rdata;
                CMBH_WORD1_IDX: w1_raw <= ram_rdata;
                default: w2_raw <= ram_rdata;
            endcase
        end
    end

    // ==========================================
    // Reserved bits read as zero
    cmbh_field_mask #(.MASK(CMBH_W0_IMPL_MASK)) u_mask0 (
        .raw(w0_raw),
        .masked(word0_view)
    );
    cmbh_field_mask #(.MASK(CMBH_W1_IMPL_MASK)) u_mask1 (
        .raw(w1_raw),
        .masked(word1_view)
    );

    // ==========================================
    // Header decode
    logic [CMBH_SID_W-1:0] sid;
    logic [CMBH_EIDU_W-1:0] eid_hi;
    logic [CMBH_EIDL_W-1:0] eid_lo;
    logic ext_fmt;
    logic remote_req;
    cmbh_hdr_s next_hdr;
    logic [CMBH_WORD_W-1:0] w2_live;

    // Word 2 is still on the RAM port in DONE; take it from there so the
    // header never pairs with word 2 of the previous buffer
    assign w2_live = (rd_pend && (pend_idx == CMBH_WORD2_IDX)) ? ram_rdata : w2_raw;

    assign sid = word0_view[CMBH_W0_SID_MSB:CMBH_W0_SID_LSB];
    assign eid_hi = word1_view[CMBH_W1_EIDU_MSB:0];
    assign eid_lo = w2_live[CMBH_WORD_W-1 -: CMBH_EIDL_W];
    assign ext_fmt = word0_view[CMBH_W0_IDE_BIT];
    assign remote_req = !ext_fmt && word0_view[CMBH_W0_SRR_BIT];

    always_comb begin
        next_hdr.extended = ext_fmt;
        next_hdr.remote = remote_req;
        if (ext_fmt) begin
            next_hdr.identifier = {sid, eid_hi, eid_lo};
            next_hdr.kind = CMBH_EXT_DATA;
        end else begin
            next_hdr.identifier = {{(CMBH_ID_W-CMBH_SID_W){1'b0}}, sid};
            next_hdr.kind = remote_req ? CMBH_STD_REMOTE : CMBH_STD_DATA;
        end
    end

    // Registered header output
    always_ff @(posedge clk) begin
        if (reset) begin
            hdr <= '0;
            hdr_valid <= 1'b0;
        end else begin
            hdr_valid <= (state == CMBH_DONE);
            if (state == CMBH_DONE) begin
                hdr <= next_hdr;
            end
        end
    end

    // ==========================================
    // Checks
    sequence fetch_seq;
        (state == CMBH_IDLE) && start ##1 ram_rd ##1 ram_rd ##1 ram_rd;
    endsequence

    fetch_three_a: assert property (@(posedge clk) disable iff (reset)
        (state == CMBH_IDLE) && start |-> ##1 ram_rd[*3] ##1 !ram_rd)
        else $error("header fetch did not read three words");
    fetch_done_a: assert property (@(posedge clk) disable iff (reset)
        fetch_seq |-> ##2 hdr_valid)
        else $error("header not valid after fetch");
    base_addr_a: assert property (@(posedge clk) disable iff (reset)
        (state == CMBH_RD0) |-> ram_addr == buf_base)
        else $error("word 0 not read at buffer base");
    w0_zero_a: assert property (@(posedge clk) disable iff (reset)
        word0_view[CMBH_WORD_W-1:CMBH_W0_SID_MSB+1] == '0)
        else $error("word 0 upper bits not zero");
    w1_zero_a: assert property (@(posedge clk) disable iff (reset)
        word1_view[CMBH_WORD_W-1:CMBH_W1_EIDU_MSB+1] == '0)
        else $error("word 1 upper bits not zero");
    remote_std_a: assert property (@(posedge clk) disable iff (reset)
        hdr_valid && hdr.remote |-> !hdr.extended && hdr.kind == CMBH_STD_REMOTE)
        else $error("remote flag on wrong frame kind");
    ide_fmt_a: assert property (@(posedge clk) disable iff (reset)
        (state == CMBH_DONE) |=> hdr.extended == $past(word0_view[CMBH_W0_IDE_BIT]))
        else $error("format bit not followed");
    ext_id_a: assert property (@(posedge clk) disable iff (reset)
        hdr_valid && hdr.extended |-> hdr.identifier[CMBH_ID_W-1 -: CMBH_SID_W] ==
            word0_view[CMBH_W0_SID_MSB:CMBH_W0_SID_LSB])
        else $error("base identifier not above extension");

    // Address walk, refused starts and the remaining identifier fields
    sequence word2_back_seq;
        rd_pend && (pend_idx == CMBH_WORD2_IDX);
    endsequence

    addr_step_a: assert property (@(posedge clk) disable iff (reset)
        (state == CMBH_RD1) || (state == CMBH_RD2) |-> ram_addr == $past(ram_addr) + ADDR_W'(1))
        else $error("buffer words not read in order");
    busy_refuse_a: assert property (@(posedge clk) disable iff (reset)
        busy && start |=> state != CMBH_RD0)
        else $error("start taken while busy");
    low_ext_a: assert property (@(posedge clk) disable iff (reset)
        word2_back_seq |=> hdr_valid && (!hdr.extended ||
            hdr.identifier[CMBH_EIDL_W-1:0] == $past(ram_rdata[CMBH_WORD_W-1 -: CMBH_EIDL_W])))
        else $error("low extension bits not from word 2");
    mid_ext_a: assert property (@(posedge clk) disable iff (reset)
        hdr_valid && hdr.extended |->
            hdr.identifier[CMBH_EIDL_W +: CMBH_EIDU_W] == word1_view[CMBH_W1_EIDU_MSB:0])
        else $error("extension bits out of place");
    std_id_a: assert property (@(posedge clk) disable iff (reset)
        hdr_valid && !hdr.extended |->
            hdr.identifier == CMBH_ID_W'(word0_view[CMBH_W0_SID_MSB:CMBH_W0_SID_LSB]))
        else $error("standard identifier not right aligned");
endmodule // cmbh_header_reader
`default_nettype wire

//--- cmbh_pkg.sv
/*
 Package for the message buffer header block: word layouts, field positions,
 frame kinds and the decoded header struct for the frame builder.
 Assumes a 16-bit data RAM shared by software and the controller.
*/
`default_nettype none
package cmbh_pkg;
    // ==========================================
    // Widths and field positions
    localparam int CMBH_WORD_W = 16;
    localparam int CMBH_SID_W = 11;
    localparam int CMBH_EIDU_W = 12;
    localparam int CMBH_EIDL_W = 6;
    localparam int CMBH_ID_W = 29;
    localparam int CMBH_W0_SID_LSB = 2;
    localparam int CMBH_W0_SID_MSB = 12;
    localparam int CMBH_W0_SRR_BIT = 1;
    localparam int CMBH_W0_IDE_BIT = 0;
    localparam int CMBH_W1_EIDU_MSB = 11;
    localparam logic [15:0] CMBH_W0_IMPL_MASK = 16'h1FFF;
    localparam logic [15:0] CMBH_W1_IMPL_MASK = 16'h0FFF;
    localparam logic [1:0] CMBH_WORD0_IDX = 2'h0;
    localparam logic [1:0] CMBH_WORD1_IDX = 2'h1;
    localparam logic [1:0] CMBH_WORD2_IDX = 2'h2;

    // ==========================================
    // Frame kinds
    typedef enum logic [1:0] {
        CMBH_STD_DATA = 2'b00,
        CMBH_STD_REMOTE = 2'b01,
        CMBH_EXT_DATA = 2'b10
    } cmbh_kind_e;

    // Decoded header handed to the frame builder
    typedef struct packed {
        logic [CMBH_ID_W-1:0] identifier;
        logic extended;
        logic remote;
        cmbh_kind_e kind;
    } cmbh_hdr_s;
endpackage : cmbh_pkg
`default_nettype wire

//--- cmbh_ram_model.sv
/*
 Far-side data RAM that holds message buffers; software writes via wr_*.
 Assumes the reader's one-cycle read latency on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cmbh_ram_model #(
    parameter int ADDR_W = 12
) (
    input wire logic clk, // System clock
    input wire logic wr_en, // Software write strobe
    input wire logic [ADDR_W-1:0] wr_addr, // Software word address
    input wire logic [15:0] wr_data, // Software write data
    input wire logic ram_rd, // Controller read strobe
    input wire logic [ADDR_W-1:0] ram_addr, // Controller word address
    output logic [15:0] ram_rdata // Data one cycle after strobe
);
    // ==========================================
    // Storage and read port
    logic [15:0] mem [2**ADDR_W];
    // Plain memory writes; reads at any base; idle data keeps toggling
    always_ff @(posedge clk) begin
        if (wr_en) mem[wr_addr] <= wr_data;
        ram_rdata <= ram_rd ? mem[ram_addr] : ~ram_rdata;
    end
endmodule // cmbh_ram_model
`default_nettype wire

//--- tb_can_message_buffer_header.sv
/*
 Testbench: loads buffer headers into the RAM model and fetches them.
 Assumes the reader and RAM model share one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_can_message_buffer_header;
    import cmbh_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [11:0] buf_base = 12'h000;
    logic wr_en = 1'b0;
    logic [11:0] wr_addr = 12'h000;
    logic [15:0] wr_data = 16'h0000;
    logic busy, ram_rd, hdr_valid;
    logic [11:0] ram_addr;
    logic [15:0] ram_rdata, word0_view, word1_view;
    cmbh_hdr_s hdr;
    int errors = 0;
    int tests_run = 0;
    // Case table: base, word 0, word 1, word 2 (extended cases keep bit 1 set)
    logic [11:0] bases [4] = '{12'h000, 12'h3A5, 12'h800, 12'hFFD};
    logic [15:0] w0s [4] = '{16'hFFFC, 16'h2AAA, 16'hF557, 16'h0003};
    logic [15:0] w1s [4] = '{16'hFFFF, 16'hF000, 16'h5A5A, 16'hF001};
    logic [15:0] w2s [4] = '{16'h1234, 16'hFFFF, 16'hFC00, 16'h03FF};

    always #5 clk = ~clk;

    cmbh_header_reader #(.ADDR_W(12)) DUT (.clk(clk), .reset(reset), .buf_base(buf_base),
        .start(start), .busy(busy), .ram_rd(ram_rd), .ram_addr(ram_addr),
        .ram_rdata(ram_rdata), .word0_view(word0_view), .word1_view(word1_view),
        .hdr(hdr), .hdr_valid(hdr_valid));
    cmbh_ram_model #(.ADDR_W(12)) far_ram (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .ram_rd(ram_rd), .ram_addr(ram_addr), .ram_rdata(ram_rdata));

    // ==========================================
    // Compare, verdict and access tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out();
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic load(input int k);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            wr_en <= 1'b1;
            wr_addr <= bases[k] + 12'(i);
            wr_data <= (i == 0) ? w0s[k] : (i == 1) ? w1s[k] : w2s[k];
        end
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic fetch(input int k);
        int n;
        logic ext;
        logic rem;
        logic [28:0] id;
        n = 0;
        ext = w0s[k][0];
        rem = !w0s[k][0] & w0s[k][1];
        id = ext ? {w0s[k][12:2], w1s[k][11:0], w2s[k][15:10]} : {18'h0, w0s[k][12:2]};
        @(posedge clk);
        buf_base <= bases[k];
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        // Case 1 sends a second start while busy; it must be ignored
        do begin
            @(posedge clk);
            start <= (k == 1 && n == 0);
            #1;
            n++;
        end while (hdr_valid !== 1'b1 && n < 20);
        check("latency", 32'd4, 32'(n));
        check("identifier", {3'h0, id}, {3'h0, hdr.identifier});
        check("extended", {31'h0, ext}, {31'h0, hdr.extended});
        check("remote", {31'h0, rem}, {31'h0, hdr.remote});
        check("kind", ext ? 32'(CMBH_EXT_DATA) : rem ? 32'(CMBH_STD_REMOTE) : 32'(CMBH_STD_DATA),
            {30'h0, hdr.kind});
        check("word0 view", {16'h0, w0s[k] & 16'h1FFF}, {16'h0, word0_view});
        check("word1 view", {16'h0, w1s[k] & 16'h0FFF}, {16'h0, word1_view});
        if (k == 1) repeat (6) begin
            @(posedge clk);
            #1;
            check("refused start", 32'h0, {29'h0, busy, ram_rd, hdr_valid});
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check("reset state", 32'h0, {29'h0, busy, ram_rd, hdr_valid});
        for (int k = 0; k < 4; k++) load(k);
        for (int k = 0; k < 4; k++) fetch(k);
        close_out();
    end

    // Watchdog against a hung fetch
    initial begin
        #20000;
        errors++;
        close_out();
    end
endmodule // tb_can_message_buffer_header
`default_nettype wire
